// ### logic/bst_top.sv
// Boundary-scan tap top level
`timescale 1ns/1ps

// What this block does
// - Sixteen states, next state from sampled tms
// - Select output high for instruction path
// - Capture loads parallel; shift moves bits serially
// - Update loads instruction or boundary output stages
// - Separate capture/shift/update strobes, enable, reset
// - Four boundary cells per pad block, chained
// - Data and direction cells, shift feeding update
// - Cells run on controller strobes and mode
// - Indicator picks pad input or functional data
// - External test drives pads from update stages
// - Bypass or sample keep functional pad data
// - Normal mode passes functional data both ways
// - Sample inputs on rise, change tdo on fall
// - External test updates pads on falling edge
// - Three-bit instruction codes 000, 100, 011, 111
// - Bypass uses one flip-flop of delay
module bst_top #(
    parameter int          BLOCKS   = 1,            // Pad blocks
    parameter logic [31:0] ID_VALUE = 32'h1357_9BDF // Arbitrary value
) (
    // System clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Test link pins
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    output logic                             tdo,
    output logic                             tdo_oe,
    // Reset pins, active low
    input  wire logic                        power_up_reset_n,
    input  wire logic                        scan_reset_n,
    // Controller strobes
    output bst_pkg::bst_ctl_t                ctl,
    // Pads
    input  wire logic [4*BLOCKS-1:0]         pad_in,
    output logic      [4*BLOCKS-1:0]         pad_out,
    output logic      [4*BLOCKS-1:0]         pad_oe,
    // AXI4-Lite write address and data
    input  wire logic [bst_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    // AXI4-Lite write response
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    // AXI4-Lite read
    input  wire logic [bst_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready
);
    import bst_pkg::*;

    localparam int PADS = CELLS_PER_BLOCK * BLOCKS;

    typedef struct packed {
        // Pin synchronisers, first stage read only by second
        logic              tck1;
        logic              tck2;
        logic              tck3;     // Previous tck2 for edges
        logic              tms1;
        logic              tms2;
        logic              tdi1;
        logic              tdi2;
        logic              pur1;
        logic              pur2;
        logic              scn1;
        logic              scn2;
        logic [PADS-1:0]   pad1;
        logic [PADS-1:0]   pad2;
        // Scan registers
        logic [IR_W-1:0]   ir;       // Active instruction
        logic [IR_W-1:0]   ir_sh;    // Instruction shift stage
        logic              byp;      // Bypass flip-flop
        logic [ID_W-1:0]   id_sh;    // Identification shift
        // Link outputs
        logic              tdo;
        logic              tdo_oe;
        bst_ctl_t          ctl;
        logic [PADS-1:0]   pad_out;
        logic [PADS-1:0]   pad_oe;
        // Software-held functional data
        logic [PADS-1:0]   func_out;
        logic [PADS-1:0]   func_oe;
        // Bus slave
        logic              awrdy;
        logic              wrdy;
        logic              have_aw;
        logic              have_w;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdat;
        logic [3:0]        wbe;
        logic              bvld;
        logic [1:0]        brsp;
        logic              arrdy;
        logic              rvld;
        logic [31:0]       rdat;
        logic [1:0]        rrsp;
    } bst_top_st_t;

    bst_top_st_t s;         // Registered state
    bst_top_st_t next_s;    // Next value
    bst_state_t  st;        // Controller state
    logic        tck_rise;  // One-cycle test clock rise
    logic        tck_fall;  // One-cycle test clock fall
    logic        hold_rst;  // Either reset pin asserted
    logic        mode;      // External test active
    logic        sel_bsr;   // Boundary register addressed
    logic        sel_id;    // Identification addressed
    logic        b_cap;     // Boundary capture
    logic        b_shn;     // Boundary shift, active low
    logic        b_upd;     // Boundary update
    logic        treset;    // Controller in reset state
    logic [PADS:0]   chain;     // Scan chain taps
    logic [PADS-1:0] cell_out;  // Cell pad data
    logic [PADS-1:0] cell_oe;   // Cell pad enables

    // Edges of the synced test clock; a slow clock
    // gives several cycles per phase, so none is lost
    always_comb begin
        tck_rise = s.tck2 && !s.tck3;
        tck_fall = !s.tck2 && s.tck3;
        hold_rst = !s.pur2 || !s.scn2;
    end

    // Port controller
    bst_tap_fsm u_fsm (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .hold_reset (hold_rst),
        .tck_rise   (tck_rise),
        .tms        (s.tms2),
        .state      (st)
    );

    // Instruction decode
    always_comb begin
        mode    = (s.ir == IR_EXTEST);
        sel_bsr = mode || (s.ir == IR_SAMPLE);
        sel_id  = (s.ir == IR_IDCODE);
        treset  = (st == TLR);
        b_cap   = sel_bsr && (st == CAP_DR);
        b_shn   = !(sel_bsr && (st == SH_DR));
        b_upd   = sel_bsr && (st == UPD_DR);
        chain[0] = s.tdi2;
    end

    // Boundary register: cells chained in pad order
    for (genvar i = 0; i < PADS; i++) begin : g_cell
        bst_cell u_cell (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .tck_rise    (tck_rise),
            .tck_fall    (tck_fall),
            .capture     (b_cap),
            .shiftn      (b_shn),
            .update      (b_upd),
            .treset      (treset),
            .mode        (mode),
            .scan_in     (chain[i]),
            .scan_out    (chain[i+1]),
            .func_out    (s.func_out[i]),
            .func_oe     (s.func_oe[i]),
            .pad_in      (s.pad2[i]),
            .pad_out_val (cell_out[i]),
            .pad_oe_val  (cell_oe[i])
        );
    end

    // Whole next state
    always_comb begin
        next_s = s;

        // Two-flop pin synchronisers
        next_s.tck1 = tck;
        next_s.tck2 = s.tck1;
        next_s.tck3 = s.tck2;
        next_s.tms1 = tms;
        next_s.tms2 = s.tms1;
        next_s.tdi1 = tdi;
        next_s.tdi2 = s.tdi1;
        next_s.pur1 = power_up_reset_n;
        next_s.pur2 = s.pur1;
        next_s.scn1 = scan_reset_n;
        next_s.scn2 = s.scn1;
        next_s.pad1 = pad_in;
        next_s.pad2 = s.pad1;

        // Capture and shift on test clock rise
        if (tck_rise) begin
            unique case (st)
                CAP_IR: next_s.ir_sh = IR_CAPTURE;
                SH_IR:  next_s.ir_sh = {s.tdi2, s.ir_sh[IR_W-1:1]};
                CAP_DR: begin
                    next_s.byp = 1'b0;
                    if (sel_id) next_s.id_sh = ID_VALUE;
                end
                SH_DR: begin
                    next_s.byp   = s.tdi2;
                    next_s.id_sh = {s.tdi2, s.id_sh[ID_W-1:1]};
                end
                default: begin
                    // Other states leave the shift stages alone
                end
            endcase
        end

        // Serial output moves on the fall
        if (tck_fall) begin
            if (st == UPD_IR) next_s.ir = s.ir_sh;
            next_s.tdo_oe = (st == SH_DR) || (st == SH_IR);
            if (st == SH_IR) begin
                next_s.tdo = s.ir_sh[0];
            end else if (sel_bsr) begin
                next_s.tdo = chain[PADS];
            end else if (sel_id) begin
                next_s.tdo = s.id_sh[0];
            end else begin
                next_s.tdo = s.byp;
            end
        end

        // Reset state restores the id instruction
        if (treset) begin
            next_s.ir = IR_RESET;
        end
        if (hold_rst) begin
            next_s.tdo_oe = 1'b0;
        end

        // Registered controller strobes
        next_s.ctl.select_ir = (st >= SEL_IR);
        next_s.ctl.tdo_en    = s.tdo_oe;
        next_s.ctl.treset    = treset;
        next_s.ctl.cap_dr    = (st == CAP_DR);
        next_s.ctl.cap_ir    = (st == CAP_IR);
        next_s.ctl.sh_dr     = (st == SH_DR);
        next_s.ctl.sh_ir     = (st == SH_IR);
        next_s.ctl.upd_dr    = (st == UPD_DR);
        next_s.ctl.upd_ir    = (st == UPD_IR);

        // Pads follow the cells
        next_s.pad_out = cell_out;
        next_s.pad_oe  = cell_oe;

        // Address and data in either order
        if (awvalid && s.awrdy) begin
            next_s.have_aw = 1'b1;
            next_s.waddr   = awaddr;
        end
        if (wvalid && s.wrdy) begin
            next_s.have_w = 1'b1;
            next_s.wdat   = wdata;
            next_s.wbe    = wstrb;
        end

        // Write once both halves are held
        if (s.have_aw && s.have_w && !s.bvld) begin
            next_s.have_aw = 1'b0;
            next_s.have_w  = 1'b0;
            next_s.bvld    = 1'b1;
            next_s.brsp    = RESP_OKAY;
            unique case (bst_word(s.waddr))
                REG_FUNC_OUT: next_s.func_out = PADS'(bst_merge(
                    32'(s.func_out), s.wdat, s.wbe));
                REG_FUNC_OE:  next_s.func_oe = PADS'(bst_merge(
                    32'(s.func_oe), s.wdat, s.wbe));
                REG_STATUS, REG_PAD_IN: begin
                    // Read-only words ignore writes
                end
                default: next_s.brsp = RESP_SLVERR;
            endcase
        end else if (s.bvld && bready) begin
            next_s.bvld = 1'b0;
        end

        // Read answers one cycle later
        if (arvalid && s.arrdy) begin
            next_s.rvld = 1'b1;
            next_s.rrsp = RESP_OKAY;
            next_s.rdat = '0;
            unique case (bst_word(araddr))
                REG_STATUS: begin
                    next_s.rdat[ST_STATE_LSB +: 4]  = st;
                    next_s.rdat[ST_IR_LSB +: IR_W] = s.ir;
                    next_s.rdat[ST_MODE_BIT]        = mode;
                    next_s.rdat[ST_TDOE_BIT]        = s.tdo_oe;
                end
                REG_FUNC_OUT: next_s.rdat[PADS-1:0] = s.func_out;
                REG_FUNC_OE:  next_s.rdat[PADS-1:0] = s.func_oe;
                REG_PAD_IN:   next_s.rdat[PADS-1:0] = s.pad2;
                default:      next_s.rrsp = RESP_SLVERR;
            endcase
        end else if (s.rvld && rready) begin
            next_s.rvld = 1'b0;
        end

        // Each ready only while its own half is not held and no answer is owed
        next_s.awrdy = !next_s.have_aw && !next_s.bvld;
        next_s.wrdy  = !next_s.have_w && !next_s.bvld;
        next_s.arrdy = !next_s.rvld;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.ir       <= IR_RESET;
            s.func_out <= PADS'(FUNC_RST);
            s.func_oe  <= PADS'(FUNC_RST);
            s.pur1     <= 1'b1;
            s.pur2     <= 1'b1;
            s.scn1     <= 1'b1;
            s.scn2     <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs from flops
    always_comb begin
        tdo     = s.tdo;
        tdo_oe  = s.tdo_oe;
        ctl     = s.ctl;
        pad_out = s.pad_out;
        pad_oe  = s.pad_oe;
        awready = s.awrdy;
        wready  = s.wrdy;
        bvalid  = s.bvld;
        bresp   = s.brsp;
        arready = s.arrdy;
        rvalid  = s.rvld;
        rdata   = s.rdat;
        rresp   = s.rrsp;
    end

endmodule : bst_top

// ### logic/bst_pkg.sv
// Shared constants, types and helpers for the boundary-scan tap block
package bst_pkg;

    // Test access port controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bst_state_t;

    // Controller strobes presented to the pad side
    typedef struct packed {
        logic select_ir;  // High: instruction path chosen
        logic tdo_en;     // Serial output enable
        logic treset;     // Test logic reset
        logic cap_dr;
        logic cap_ir;
        logic sh_dr;
        logic sh_ir;
        logic upd_dr;
        logic upd_ir;
    } bst_ctl_t;

    // Instruction register
    localparam int         IR_W       = 3;
    localparam logic [2:0] IR_EXTEST  = 3'h0;
    localparam logic [2:0] IR_IDCODE  = 3'h3;
    localparam logic [2:0] IR_SAMPLE  = 3'h4;
    localparam logic [2:0] IR_BYPASS  = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    localparam logic [2:0] IR_RESET   = IR_IDCODE;
    localparam int         ID_W       = 32;

    // Pad blocks hold four cells each
    localparam int CELLS_PER_BLOCK = 4;

    // Register map, byte addresses
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] REG_STATUS   = 8'h00;
    localparam logic [7:0] REG_FUNC_OUT = 8'h04;
    localparam logic [7:0] REG_FUNC_OE  = 8'h08;
    localparam logic [7:0] REG_PAD_IN   = 8'h0C;

    // Status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_IR_LSB    = 4;
    localparam int ST_MODE_BIT  = 7;
    localparam int ST_TDOE_BIT  = 8;

    // Reset values and bus answers
    localparam logic [31:0] FUNC_RST    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] bst_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction : bst_merge

    // Word-aligned form of a bus address
    function automatic logic [7:0] bst_word(input logic [7:0] a);
        return {a[7:2], 2'h0};
    endfunction : bst_word

endpackage : bst_pkg

// ### logic/bst_tap_fsm.sv
// Sixteen-state port controller
`timescale 1ns/1ps
module bst_tap_fsm (
    // Clock and reset
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // Sampled link inputs
    input  wire logic           hold_reset,
    input  wire logic           tck_rise,
    input  wire logic           tms,
    // Current state
    output bst_pkg::bst_state_t state
);
    import bst_pkg::*;

    typedef struct packed {
        bst_state_t st;
    } bst_fsm_t;

    bst_fsm_t s;       // Registered state
    bst_fsm_t next_s;  // Next value

    // Next state from tms at a test clock rise
    always_comb begin
        next_s = s;
        if (hold_reset) begin
            next_s.st = TLR;
        end else if (tck_rise) begin
            unique case (s.st)
                TLR:    next_s.st = tms ? TLR    : RTI;
                RTI:    next_s.st = tms ? SEL_DR : RTI;
                SEL_DR: next_s.st = tms ? SEL_IR : CAP_DR;
                CAP_DR: next_s.st = tms ? EX1_DR : SH_DR;
                SH_DR:  next_s.st = tms ? EX1_DR : SH_DR;
                EX1_DR: next_s.st = tms ? UPD_DR : PA_DR;
                PA_DR:  next_s.st = tms ? EX2_DR : PA_DR;
                EX2_DR: next_s.st = tms ? UPD_DR : SH_DR;
                UPD_DR: next_s.st = tms ? SEL_DR : RTI;
                SEL_IR: next_s.st = tms ? TLR    : CAP_IR;
                CAP_IR: next_s.st = tms ? EX1_IR : SH_IR;
                SH_IR:  next_s.st = tms ? EX1_IR : SH_IR;
                EX1_IR: next_s.st = tms ? UPD_IR : PA_IR;
                PA_IR:  next_s.st = tms ? EX2_IR : PA_IR;
                EX2_IR: next_s.st = tms ? UPD_IR : SH_IR;
                UPD_IR: next_s.st = tms ? SEL_DR : RTI;
            endcase
        end
    end

    // State register; bus reset gives TLR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{st: TLR};
        end else begin
            s <= next_s;
        end
    end

    assign state = s.st;

endmodule : bst_tap_fsm

// ### logic/bst_cell.sv
// One boundary cell: data cell chained into a direction cell
`timescale 1ns/1ps
module bst_cell (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Test clock edge strobes
    input  wire logic tck_rise,
    input  wire logic tck_fall,
    // Controller strobes
    input  wire logic capture,
    input  wire logic shiftn,
    input  wire logic update,
    input  wire logic treset,
    input  wire logic mode,
    // Scan chain
    input  wire logic scan_in,
    output logic      scan_out,
    // Functional and pad side
    input  wire logic func_out,
    input  wire logic func_oe,
    input  wire logic pad_in,
    output logic      pad_out_val,
    output logic      pad_oe_val
);
    import bst_pkg::*;

    typedef struct packed {
        logic dat_sh;  // Data shift stage
        logic dat_up;  // Data update stage
        logic dir_sh;  // Direction shift stage
        logic dir_up;  // Direction update stage
    } bst_cell_st_t;

    bst_cell_st_t s;       // Registered state
    bst_cell_st_t next_s;  // Next value
    logic         dir_ind; // Output direction indicator

    // Indicator uses scan value only in external test
    always_comb begin
        dir_ind = mode ? s.dir_up : func_oe;
    end

    // Capture, shift and update of both stages
    always_comb begin
        next_s = s;
        if (tck_rise && capture) begin
            next_s.dat_sh = dir_ind ? func_out : pad_in;
            next_s.dir_sh = func_oe;
        end else if (tck_rise && !shiftn) begin
            next_s.dat_sh = scan_in;
            next_s.dir_sh = s.dat_sh;
        end
        if (tck_fall && update) begin
            next_s.dat_up = s.dat_sh;
            next_s.dir_up = s.dir_sh;
        end
        if (treset) begin
            next_s.dat_up = 1'b0;
            next_s.dir_up = 1'b0;
        end
    end

    // Cell register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Pad drive: scan data in external test
    always_comb begin
        scan_out    = s.dir_sh;
        pad_out_val = mode ? s.dat_up : func_out;
        pad_oe_val  = mode ? s.dir_up : func_oe;
    end

endmodule : bst_cell

// ### bench/bst_top_chk.sv
// Port-level assertions for the boundary-scan tap
`timescale 1ns/1ps
module bst_top_chk #(
    parameter int BLOCKS = 1  // Pad blocks
) (
    // Clock and resets
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              power_up_reset_n,
    input wire logic              scan_reset_n,
    // Link and strobes
    input wire logic              tck,
    input wire logic              tdo,
    input wire logic              tdo_oe,
    input wire bst_pkg::bst_ctl_t ctl,
    // Read channel
    input wire logic              arvalid,
    input wire logic              arready,
    input wire logic              rvalid
);
    import bst_pkg::*;
    // One clock domain
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Sync and strobe lag fit in six
    rst_hold_a: assert property (
        (!power_up_reset_n || !scan_reset_n) [*6] |-> ctl.treset && !tdo_oe)
        else $error("pin reset not held");
    oe_in_shift_a: assert property (
        $rose(tdo_oe) |-> ctl.sh_dr || ctl.sh_ir)
        else $error("enable outside shift");
    // Pin is still low three cycles after a fall
    tdo_on_fall_a: assert property (
        $changed(tdo) |-> !$past(tck, 3))
        else $error("tdo moved off a fall");
    ir_select_a: assert property (
        ctl.cap_ir || ctl.sh_ir || ctl.upd_ir |-> ctl.select_ir)
        else $error("ir strobe unselected");
    dr_select_a: assert property (
        ctl.cap_dr || ctl.sh_dr || ctl.upd_dr || ctl.treset |-> !ctl.select_ir)
        else $error("dr strobe with ir select");
    one_strobe_a: assert property (
        $onehot0({ctl.cap_dr, ctl.cap_ir, ctl.sh_dr, ctl.sh_ir,
                  ctl.upd_dr, ctl.upd_ir, ctl.treset}))
        else $error("two strobes at once");
    capir_entry_a: assert property (
        $rose(ctl.cap_ir) |-> $past(ctl.select_ir))
        else $error("bad ir capture entry");
    capdr_entry_a: assert property (
        $rose(ctl.cap_dr) |-> !$past(ctl.select_ir) && !$past(ctl.treset))
        else $error("bad dr capture entry");
    rd_answer_a: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer late");
endmodule : bst_top_chk

bind bst_top bst_top_chk #(.BLOCKS(BLOCKS)) u_chk (.*);

// ### bench/bst_host.sv
// Scan host model for the test link
`timescale 1ns/1ps
module bst_host (
    // Link toward the tap
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // Clock stands low outside frames
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
    end
    // One 160 ns period, edges between system clock rises
    task automatic step(input logic m, input logic v, output logic so,
        output logic oe);
        tms = m;
        tdi = v;
        #70 tck = 1'h1;
        #78 so = tdo;
        oe = tdo_oe;
        #2 tck = 1'h0;
        #10;
    endtask : step
    // Released data line shows a new level
    task automatic park;
        tdi = ~tdi;
    endtask : park
endmodule : bst_host

// ### bench/bst_top_tb.sv
// Self-checking bench for the boundary-scan tap
`timescale 1ns/1ps
module bst_top_tb;
    import bst_pkg::*;
    localparam logic [31:0] ID = 32'h2468_ACE1;  // Arbitrary identity
    logic        aclk = 1'h0;              // 50 MHz clock
    logic        aresetn = 1'h0;           // Held at start
    logic        power_up_reset_n = 1'h1;  // Pin resets idle high
    logic        scan_reset_n = 1'h1;
    logic        tck, tms, tdi, tdo, tdo_oe, so, oe;
    bst_ctl_t    ctl;
    logic [3:0]  pad_in = 4'h0, pad_out, pad_oe;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d, x, fo, fe;
    logic [3:0]  wstrb = 4'hF;             // Whole words only
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] seed = 32'h0000_886E;     // Fixed xorshift start
    int          mismatches = 0;
    int          samples_checked = 0;
    always #10 aclk = ~aclk;
    bst_top #(.ID_VALUE(ID)) DUT (.*);
    bst_host u_host (.*);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Captured chain; bit 0 is the last direction cell
    function automatic logic [7:0] chain(input logic [3:0] o, e, p);
        logic [7:0] c;
        for (int k = 0; k < 4; k++) begin
            c[7-2*k] = e[k] ? o[k] : p[k];
            c[6-2*k] = e[k];
        end
        return c;
    endfunction : chain
    // Cells of one kind: 0 data, 1 direction
    function automatic logic [3:0] pick(input logic [7:0] v, input int s);
        logic [3:0] q;
        for (int k = 0; k < 4; k++) q[k] = v[7-2*k-s];
        return q;
    endfunction : pick
    task automatic chk(input logic [31:0] g, e, input string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checked %0d, unexpected %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Write; channels drop once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            n++;
        end while (!bvalid && n < 40);
        bready <= 1'h0;
        chk(bresp, RESP_OKAY, "write answer");
        if (n >= 40) mismatches++;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            n++;
        end while (!rvalid && n < 40);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        if (n >= 40) mismatches++;
        @(posedge aclk);
    endtask : axi_rd
    // Frame from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] v);
        u_host.step(1'h1, 1'h0, so, oe);
        if (ir) u_host.step(1'h1, 1'h0, so, oe);
        repeat (2) u_host.step(1'h0, 1'h0, so, oe);
        d = 32'h0;
        for (int i = 0; i < n; i++) begin
            u_host.step(i == n - 1, v[i], so, oe);
            d[i] = so;
            chk(oe, 1'h1, "enable in shift");
        end
        u_host.step(1'h1, 1'h0, so, oe);
        u_host.step(1'h0, 1'h0, so, oe);
        chk(oe, 1'h0, "enable after update");
        u_host.park;
    endtask : scan
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        chk(ctl.treset, 1'h1, "reset strobe");
        axi_rd(REG_STATUS);
        chk(d[8:0], {2'h0, IR_IDCODE, 4'h0}, "status");
        u_host.step(1'h0, 1'h0, so, oe);
        scan(1'h0, 32, rnd());
        chk(d, ID, "identity");
        scan(1'h1, 3, IR_BYPASS);
        chk(d[2:0], IR_CAPTURE, "ir capture");
        x = rnd();
        scan(1'h0, 16, x);
        chk(d[15:0], {x[14:0], 1'h0}, "bypass delay");
        $display("test id and bypass done");
        repeat (3) begin
            fo = rnd();
            fe = rnd();
            pad_in <= fo[7:4] ^ fe[7:4];
            axi_wr(REG_FUNC_OUT, fo);
            axi_wr(REG_FUNC_OE, fe);
            scan(1'h1, 3, IR_SAMPLE);
            chk(pad_out, fo[3:0], "func out");
            chk(pad_oe, fe[3:0], "func enable");
            axi_rd(REG_PAD_IN);
            chk(d[3:0], pad_in, "pad input");
            scan(1'h0, 8, rnd());
            chk(d[7:0], chain(fo[3:0], fe[3:0], pad_in), "chain");
        end
        $display("test sample done");
        scan(1'h1, 3, IR_EXTEST);
        axi_rd(REG_STATUS);
        chk(d[7], 1'h1, "test mode");
        x = rnd();
        scan(1'h0, 8, x);
        chk(pad_out, pick(x[7:0], 0), "scan pads");
        chk(pad_oe, pick(x[7:0], 1), "scan enables");
        axi_rd(8'h40);
        chk(r, RESP_SLVERR, "unmapped read");
        $display("test external done");
        for (int k = 0; k < 2; k++) begin
            {power_up_reset_n, scan_reset_n} <= k ? 2'h2 : 2'h1;
            repeat (8) @(posedge aclk);
            chk(ctl.treset, 1'h1, "pin reset");
            {power_up_reset_n, scan_reset_n} <= 2'h3;
            axi_rd(REG_STATUS);
            chk(d[6:0], {IR_IDCODE, 4'h0}, "after pin reset");
            chk(pad_out, fo[3:0], "pads back to logic");
        end
        $display("test resets done");
        tally_and_finish;
    end
    // Hang guard, far past the run length
    initial begin
        #1_000_000;
        mismatches++;
        tally_and_finish;
    end
endmodule : bst_top_tb
